// ---- logic/lvpc_config.sv ----
// Contract
// [R1] Selector 3 frame: bytes 0,1 are park position low, high.
// [R2] After reset, actual position loads the stored park position, no homing; reset here clears the stored groups, so park and actual both start at zero.
// [R3] Master sets each requested position to park before reset or power down.
// [R4] At-park flag is high whenever actual position equals park position.
// [R5] Selector 3 bytes 2,3 are a signed correction added to actual position.
// [R6] Selector 2 bytes 2,3 give reset value loaded on position-reset request.
// [R7] Respond only after an upload request carrying this node's identifier.
// [R8] Service 0x00 sleeps, 0x01 to 0x7F ignored, 0x80 requests upload.
// [R9] Response carries the current 8-bit node identifier.
// [R10] Response carries the current axis configuration code.
// [R11] Response selector echoes the request selector.
// [R12] Response data bytes return the stored group in request layout.
// [R13] Selector 1 byte 0 is start/stop frequency code times fixed resolution.
// [R14] Positions are two's complement low/high pairs kept within range; only the correction sum is clamped, park and reset values load unchecked.
`timescale 1ns/1ps
module lvpc_config (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CE,
  // Node identity
  input wire logic [7:0] NODE_ID,
  input wire logic [7:0] AXIS_CONFIG,
  // Broadcast configuration frame
  input wire logic CFG_VALID,
  input wire lvpc_pkg::lvpc_cfg_t CFG_FRAME,
  // Service request frame
  input wire logic REQ_VALID,
  input wire lvpc_pkg::lvpc_req_t REQ_FRAME,
  // Response slot header and response frame
  input wire logic RESP_SLOT,
  output logic RESP_VALID,
  output lvpc_pkg::lvpc_resp_t RESP_FRAME,
  // Motion side
  input wire logic POS_RESET_REQ,
  output logic signed [15:0] ACTUAL_POSITION,
  output logic signed [15:0] PARK_POSITION,
  output logic AT_PARK_FLAG,
  output logic [15:0] START_STOP_FREQUENCY,
  output logic SLEEP_PULSE,
  output logic UPLOAD_PENDING
);
  import lvpc_pkg::*;

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    lvpc_mode_t mode;
    logic [LVPC_NUM_GROUPS-1:0][3:0][7:0] groups;
    logic signed [15:0] actual;
    logic at_park;
    logic armed;
    logic [LVPC_SEL_W-1:0] up_sel;
    logic resp_valid;
    lvpc_resp_t resp;
    logic sleep;
    logic [15:0] freq;
  } lvpc_state_t;

  lvpc_state_t st_reg;
  lvpc_state_t st_next;

  logic signed [15:0] park_cur;
  logic signed [15:0] corr_in;
  logic signed [15:0] corr_sum;
  logic signed [15:0] reset_val;
  logic cfg_sel_ok;
  logic req_sel_ok;
  logic [LVPC_SEL_W-1:0] cfg_idx;

  assign park_cur = {st_reg.groups[LVPC_SEL_PARK[LVPC_SEL_W-1:0]]
                     [LVPC_B_POS_HI],
                     st_reg.groups[LVPC_SEL_PARK[LVPC_SEL_W-1:0]]
                     [LVPC_B_POS_LO]};
  // [R6] Reset value pairing
  assign reset_val = {st_reg.groups[LVPC_SEL_RESET_POS[LVPC_SEL_W-1:0]]
                      [LVPC_B_AUX_HI],
                      st_reg.groups[LVPC_SEL_RESET_POS[LVPC_SEL_W-1:0]]
                      [LVPC_B_AUX_LO]};
  // [R14] Signed low/high pairing
  assign corr_in = {CFG_FRAME.data[LVPC_B_AUX_HI],
                    CFG_FRAME.data[LVPC_B_AUX_LO]};
  assign cfg_sel_ok = CFG_FRAME.selector <= LVPC_SEL_PARK;
  assign req_sel_ok = REQ_FRAME.selector <= LVPC_SEL_PARK;
  assign cfg_idx = CFG_FRAME.selector[LVPC_SEL_W-1:0];

  // [R5] Saturating correction
  lvpc_sat_add u_corr (
    .a(st_reg.actual),
    .b(corr_in),
    .sum(corr_sum)
  );

  // ******************************************************
  // Next state
  // ******************************************************
  always_comb begin
    st_next = st_reg;
    st_next.sleep = 1'b0;
    st_next.resp_valid = 1'b0;
    case (st_reg.mode)
      LVPC_ST_INIT: begin
        // [R2] Start at park
        st_next.actual = park_cur;
        st_next.mode = LVPC_ST_RUN;
      end
      LVPC_ST_RUN: begin
        if (CFG_VALID && cfg_sel_ok) begin
          // [R1] Store addressed group
          st_next.groups[cfg_idx] = CFG_FRAME.data;
          if (CFG_FRAME.selector == LVPC_SEL_PARK) begin
            // [R5] Apply correction
            st_next.actual = corr_sum;
          end
          if (CFG_FRAME.selector == LVPC_SEL_SPEED) begin
            // [R13] Scale frequency code
            st_next.freq = 16'(CFG_FRAME.data[LVPC_B_FREQ] *
                               LVPC_FREQ_RES_HZ);
          end
        end
        if (POS_RESET_REQ) begin
          // [R6] Position reset wins over correction
          st_next.actual = reset_val;
        end
        // Slot served first, so a same-cycle arm wins
        if (RESP_SLOT && st_reg.armed) begin
          // [R7] Answer once
          st_next.armed = 1'b0;
          st_next.resp_valid = 1'b1;
          st_next.resp.service = LVPC_SVC_UPLOAD;
          // [R9] Identifier
          st_next.resp.node_id = NODE_ID;
          // [R10] Axis code
          st_next.resp.axis = AXIS_CONFIG;
          // [R11] Echo selector
          st_next.resp.selector = 8'(st_reg.up_sel);
          // [R12] Stored group
          st_next.resp.data = st_reg.groups[st_reg.up_sel];
        end
        if (REQ_VALID) begin
          // [R8] Service decode
          if (REQ_FRAME.service == LVPC_SVC_SLEEP) begin
            st_next.sleep = 1'b1;
          end else if (REQ_FRAME.service == LVPC_SVC_UPLOAD &&
                       REQ_FRAME.node_id == NODE_ID && req_sel_ok) begin
            // [R7] Arm on own identifier
            st_next.armed = 1'b1;
            st_next.up_sel = REQ_FRAME.selector[LVPC_SEL_W-1:0];
          end
        end
      end
      default: begin
        st_next.mode = LVPC_ST_INIT;
      end
    endcase
    // [R4] Park comparison
    st_next.at_park = st_next.actual ==
      signed'({st_next.groups[LVPC_SEL_PARK[LVPC_SEL_W-1:0]][LVPC_B_POS_HI],
               st_next.groups[LVPC_SEL_PARK[LVPC_SEL_W-1:0]]
               [LVPC_B_POS_LO]});
  end

  // ******************************************************
  // Registers
  // ******************************************************
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg <= '0;
      st_reg.mode <= LVPC_ST_INIT;
      st_reg.groups <= {LVPC_NUM_GROUPS{LVPC_PARAM_RESET}};
      // Park and actual both reset to zero
      st_reg.at_park <= 1'b1;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  assign RESP_VALID = st_reg.resp_valid;
  assign RESP_FRAME = st_reg.resp;
  assign ACTUAL_POSITION = st_reg.actual;
  assign PARK_POSITION = park_cur;
  assign AT_PARK_FLAG = st_reg.at_park;
  assign START_STOP_FREQUENCY = st_reg.freq;
  assign SLEEP_PULSE = st_reg.sleep;
  assign UPLOAD_PENDING = st_reg.armed;

  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  a_init_park_load: assert property ( // [R2]
    CE && st_reg.mode == LVPC_ST_INIT |=>
      ACTUAL_POSITION == $past(PARK_POSITION) &&
      st_reg.mode == LVPC_ST_RUN)
    else $error("actual position not loaded from park");

  a_park_flag_match: assert property ( // [R4]
    AT_PARK_FLAG == (ACTUAL_POSITION == PARK_POSITION))
    else $error("at-park flag disagrees with positions");

  a_park_store: assert property ( // [R1]
    CE && st_reg.mode == LVPC_ST_RUN && CFG_VALID &&
      CFG_FRAME.selector == LVPC_SEL_PARK |=>
      PARK_POSITION == $past({CFG_FRAME.data[LVPC_B_POS_HI],
                              CFG_FRAME.data[LVPC_B_POS_LO]}))
    else $error("park position not stored");

  a_correction_range: assert property ( // [R5]
    CE && st_reg.mode == LVPC_ST_RUN && CFG_VALID && !POS_RESET_REQ &&
      CFG_FRAME.selector == LVPC_SEL_PARK |=>
      ACTUAL_POSITION == $past(corr_sum) &&
      ACTUAL_POSITION >= LVPC_POS_MIN && ACTUAL_POSITION <= LVPC_POS_MAX)
    else $error("correction not applied within range");

  a_pos_reset_load: assert property ( // [R6]
    CE && st_reg.mode == LVPC_ST_RUN && POS_RESET_REQ |=>
      ACTUAL_POSITION == $past(reset_val))
    else $error("position reset value not loaded");

  a_sleep_decode: assert property ( // [R8]
    CE && st_reg.mode == LVPC_ST_RUN && REQ_VALID &&
      REQ_FRAME.service == LVPC_SVC_SLEEP |=>
      SLEEP_PULSE ##1 (!SLEEP_PULSE || $past(REQ_VALID)) or !CE)
    else $error("sleep service not decoded");

  a_reserved_ignored: assert property ( // [R8]
    CE && REQ_VALID && !RESP_SLOT &&
      REQ_FRAME.service >= LVPC_SVC_RSVD_LO &&
      REQ_FRAME.service <= LVPC_SVC_RSVD_HI |=>
      UPLOAD_PENDING == $past(UPLOAD_PENDING) && !SLEEP_PULSE)
    else $error("reserved service had an effect");

  a_resp_needs_arm: assert property ( // [R7]
    CE && !UPLOAD_PENDING |=> !RESP_VALID)
    else $error("response without matching upload request");

  a_resp_contents: assert property ( // [R11]
    CE && RESP_SLOT && UPLOAD_PENDING |=> RESP_VALID &&
      RESP_FRAME.node_id == $past(NODE_ID) &&
      RESP_FRAME.axis == $past(AXIS_CONFIG) &&
      RESP_FRAME.selector == 8'($past(st_reg.up_sel)) &&
      RESP_FRAME.data == $past(st_reg.groups[st_reg.up_sel]))
    else $error("response fields wrong");

  a_freq_scale: assert property ( // [R13]
    CE && st_reg.mode == LVPC_ST_RUN && CFG_VALID &&
      CFG_FRAME.selector == LVPC_SEL_SPEED |=>
      START_STOP_FREQUENCY ==
      16'($past(CFG_FRAME.data[LVPC_B_FREQ]) * LVPC_FREQ_RES_HZ))
    else $error("frequency not scaled");

endmodule

// ---- logic/lvpc_pkg.sv ----
package lvpc_pkg;

  // ******************************************************
  // Service codes of the request frame
  // ******************************************************
  localparam logic [7:0] LVPC_SVC_SLEEP = 8'h00;
  localparam logic [7:0] LVPC_SVC_RSVD_LO = 8'h01;
  localparam logic [7:0] LVPC_SVC_RSVD_HI = 8'h7f;
  localparam logic [7:0] LVPC_SVC_UPLOAD = 8'h80;

  // ******************************************************
  // Parameter group selectors
  // ******************************************************
  localparam logic [7:0] LVPC_SEL_GENERAL = 8'h00;
  localparam logic [7:0] LVPC_SEL_SPEED = 8'h01;
  localparam logic [7:0] LVPC_SEL_RESET_POS = 8'h02;
  localparam logic [7:0] LVPC_SEL_PARK = 8'h03;
  localparam int LVPC_NUM_GROUPS = 4;
  localparam int LVPC_SEL_W = 2;

  // ******************************************************
  // Data byte positions inside a group
  // ******************************************************
  localparam int LVPC_B_POS_LO = 0;
  localparam int LVPC_B_POS_HI = 1;
  localparam int LVPC_B_AUX_LO = 2;
  localparam int LVPC_B_AUX_HI = 3;
  localparam int LVPC_B_FREQ = 0;

  // ******************************************************
  // Position range, reset values and scaling
  // ******************************************************
  localparam logic signed [15:0] LVPC_POS_MIN = 16'shc000;
  localparam logic signed [15:0] LVPC_POS_MAX = 16'sh3fff;
  localparam logic [31:0] LVPC_PARAM_RESET = 32'h0000_0000;
  localparam logic [15:0] LVPC_FREQ_RES_HZ = 16'h000a;
  localparam logic [7:0] LVPC_AXIS_RSVD_LO = 8'h04;

  // ******************************************************
  // Frame carriers
  // ******************************************************
  typedef struct packed {
    logic [7:0] service;
    logic [7:0] node_id;
    logic [7:0] selector;
  } lvpc_req_t;

  typedef struct packed {
    logic [7:0] selector;
    logic [3:0][7:0] data;
  } lvpc_cfg_t;

  typedef struct packed {
    logic [7:0] service;
    logic [7:0] node_id;
    logic [7:0] axis;
    logic [7:0] selector;
    logic [3:0][7:0] data;
  } lvpc_resp_t;

  typedef enum logic {LVPC_ST_INIT, LVPC_ST_RUN} lvpc_mode_t;

endpackage

// ---- logic/lvpc_sat_add.sv ----
`timescale 1ns/1ps
module lvpc_sat_add (
  // Operands
  input wire logic signed [15:0] a,
  input wire logic signed [15:0] b,
  // Clamped sum
  output logic signed [15:0] sum
);
  import lvpc_pkg::*;

  logic signed [16:0] wide;

  always_comb begin
    wide = 17'(a) + 17'(b);
    if (wide > 17'(LVPC_POS_MAX)) begin
      sum = LVPC_POS_MAX;
    end else if (wide < 17'(LVPC_POS_MIN)) begin
      sum = LVPC_POS_MIN;
    end else begin
      sum = wide[15:0];
    end
  end

endmodule

// ---- verif/lvpc_master_model.sv ----
`timescale 1ns/1ps
module lvpc_master_model
  import lvpc_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Frames toward the node
  output logic cfg_valid,
  output lvpc_cfg_t cfg_frame,
  output logic req_valid,
  output lvpc_req_t req_frame,
  output logic resp_slot
);
  // ******************************************************
  // Master frame drivers
  // ******************************************************
  initial begin
    cfg_valid = 1'b0;
    cfg_frame = '0;
    req_valid = 1'b0;
    req_frame = '0;
    resp_slot = 1'b0;
  end

  task automatic send_cfg(input logic [7:0] sel, input logic [15:0] hi,
                          input logic [15:0] lo);
    // Idle edge between transfers
    @(posedge mclk);
    #1;
    cfg_frame = {sel, hi, lo};
    cfg_valid = 1'b1;
    @(posedge mclk);
    #1;
    cfg_valid = 1'b0;
    cfg_frame = ~cfg_frame;
  endtask

  task automatic send_req(input logic [7:0] svc, input logic [7:0] id,
                          input logic [7:0] sel);
    @(posedge mclk);
    #1;
    req_frame = {svc, id, sel};
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    req_frame = ~req_frame;
  endtask

  task automatic slot();
    @(posedge mclk);
    #1;
    resp_slot = 1'b1;
    @(posedge mclk);
    #1;
    resp_slot = 1'b0;
  endtask
endmodule

// ---- verif/lin_leveller_param_config_tb.sv ----
`timescale 1ns/1ps
module lin_leveller_param_config_tb;
  import lvpc_pkg::*;
  // ******************************************************
  // Stimulus and observation
  // ******************************************************
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic pos_rst = 1'b0;
  logic ce = 1'b1;
  logic [7:0] node_id = 8'h5a;
  logic [7:0] axis = 8'h00;
  logic cfg_valid, req_valid, resp_slot, resp_valid;
  logic at_park, sleep, pending;
  lvpc_cfg_t cfg_frame;
  lvpc_req_t req_frame;
  lvpc_resp_t resp_frame;
  logic signed [15:0] act_pos, park_pos;
  logic [15:0] freq;
  logic [31:0] grp [4];
  logic [7:0] rsvd [2] = '{8'h01, 8'h7f};
  int error_cnt = 0;
  int samples_checked = 0;

  always #5 mclk = ~mclk;

  lvpc_config dut_u (.MCLK(mclk), .RESET_N(reset_n), .CE(ce),
    .NODE_ID(node_id), .AXIS_CONFIG(axis), .CFG_VALID(cfg_valid),
    .CFG_FRAME(cfg_frame), .REQ_VALID(req_valid), .REQ_FRAME(req_frame),
    .RESP_SLOT(resp_slot), .RESP_VALID(resp_valid),
    .RESP_FRAME(resp_frame), .POS_RESET_REQ(pos_rst),
    .ACTUAL_POSITION(act_pos), .PARK_POSITION(park_pos),
    .AT_PARK_FLAG(at_park), .START_STOP_FREQUENCY(freq),
    .SLEEP_PULSE(sleep), .UPLOAD_PENDING(pending));

  lvpc_master_model master_u (.mclk(mclk), .cfg_valid(cfg_valid),
    .cfg_frame(cfg_frame), .req_valid(req_valid), .req_frame(req_frame),
    .resp_slot(resp_slot));

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    step();
    chk("init_act", 16'h0000, {act_pos});
    chk("init_flag", 1'b1, at_park);
    grp[3] = 32'h0005_0100;
    master_u.send_cfg(8'h03, 16'h0005, 16'h0100);
    chk("park", 16'h0100, {park_pos});
    chk("corr_act", 16'h0005, {act_pos});
    chk("flag_off", 1'b0, at_park);
    grp[2] = 32'h0100_c000;
    master_u.send_cfg(8'h02, 16'h0100, 16'hc000);
    chk("act_kept", 16'h0005, {act_pos});
    pos_rst = 1'b1;
    step();
    pos_rst = 1'b0;
    chk("rst_act", 16'h0100, {act_pos});
    chk("flag_on", 1'b1, at_park);
    grp[3] = 32'h3fff_0100;
    master_u.send_cfg(8'h03, 16'h3fff, 16'h0100);
    chk("sat_act", 16'h3fff, {act_pos});
    grp[1] = 32'h1234_5619;
    master_u.send_cfg(8'h01, 16'h1234, 16'h5619);
    chk("freq", 16'h00fa, freq);
    master_u.send_cfg(8'h07, 16'h0000, 16'h0200);
    chk("bad_sel_park", 16'h0100, {park_pos});
    chk("bad_sel_freq", 16'h00fa, freq);
    ce = 1'b0;
    master_u.send_cfg(8'h03, 16'h0000, 16'h0200);
    chk("ce_park", 16'h0100, {park_pos});
    chk("ce_act", 16'h3fff, {act_pos});
    ce = 1'b1;
    grp[0] = 32'hdead_beef;
    master_u.send_cfg(8'h00, 16'hdead, 16'hbeef);
    master_u.send_req(LVPC_SVC_SLEEP, node_id, 8'h00);
    chk("sleep", 1'b1, sleep);
    step();
    chk("sleep_end", 1'b0, sleep);
    foreach (rsvd[i]) begin
      master_u.send_req(rsvd[i], node_id, 8'h03);
      chk("rsvd_pend", 1'b0, pending);
      chk("rsvd_sleep", 1'b0, sleep);
    end
    master_u.send_req(LVPC_SVC_UPLOAD, node_id ^ 8'h01, 8'h03);
    chk("bad_id", 1'b0, pending);
    master_u.slot();
    chk("no_resp", 1'b0, resp_valid);
    master_u.send_req(LVPC_SVC_UPLOAD, node_id, 8'h07);
    chk("bad_sel_pend", 1'b0, pending);
    for (int s = 0; s < 4; s++) begin
      axis = 8'(s);
      master_u.send_req(LVPC_SVC_UPLOAD, node_id, 8'(s));
      chk("pend", 1'b1, pending);
      master_u.slot();
      chk("resp_v", 1'b1, resp_valid);
      chk("resp", {LVPC_SVC_UPLOAD, node_id, 8'(s), 8'(s), grp[s]},
          resp_frame);
      step();
      chk("resp_end", 1'b0, resp_valid);
      chk("pend_end", 1'b0, pending);
    end
    master_u.send_req(LVPC_SVC_UPLOAD, node_id, 8'h02);
    fork
      master_u.send_req(LVPC_SVC_UPLOAD, node_id, 8'h01);
      master_u.slot();
    join
    chk("both_sel", 8'h02, resp_frame.selector);
    chk("both_pend", 1'b1, pending);
    master_u.slot();
    chk("rearm_sel", 8'h01, resp_frame.selector);
    chk("rearm_pend", 1'b0, pending);
    // Master parks the node before reset
    pos_rst = 1'b1;
    step();
    pos_rst = 1'b0;
    chk("pre_rst_park", 1'b1, at_park);
    reset_n = 1'b0;
    repeat (3) step();
    reset_n = 1'b1;
    step();
    chk("re_act", 16'h0000, {act_pos});
    chk("re_park", 16'h0000, {park_pos});
    chk("re_flag", 1'b1, at_park);
    conclude();
  end
endmodule
